// ### shared/uasfc_pkg.sv
/*
  Constants of the serial status and frame control block: register
  indexes, bit positions, reset values and bit timing.
  Assumes a register port of 3-bit index with 8-bit data.
*/
package uasfc_pkg;
  // register indexes
  localparam logic [2:0] IDX_STATUS = 3'h0;
  localparam logic [2:0] IDX_CTRL1 = 3'h1;
  localparam logic [2:0] IDX_CTRL2 = 3'h2;
  localparam logic [2:0] IDX_CTRL3 = 3'h3;
  localparam logic [2:0] IDX_DATA = 3'h4;
  localparam logic [2:0] IDX_BAUD = 3'h5;
  // serial_status bits
  localparam int ST_PERR = 7;
  localparam int ST_NOISE = 6;
  localparam int ST_FERR = 5;
  localparam int ST_OVR = 4;
  localparam int ST_RIDLE = 3;
  localparam int ST_RAVAIL = 2;
  localparam int ST_TIDLE = 1;
  localparam int ST_TEMPTY = 0;
  // serial_control_one bits
  localparam int C1_EN = 7;
  localparam int C1_DLEN = 6;
  localparam int C1_PEN = 5;
  localparam int C1_PTYPE = 4;
  localparam int C1_STOP = 3;
  localparam int C1_BRK = 2;
  localparam int C1_RX9 = 1;
  localparam int C1_TX9 = 0;
  // serial_control_two and three bits
  localparam int C2_TXEN = 7;
  localparam int C2_RXEN = 6;
  localparam int C2_RIE = 2;
  localparam int C3_SWM = 0;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  // bit timing in oversample ticks, break length in bit times
  localparam logic [3:0] OS_LAST = 4'hF;
  localparam logic [3:0] OS_VOTE_LO = 4'h7;
  localparam logic [3:0] OS_VOTE_HI = 4'h9;
  localparam logic [3:0] BREAK_BITS = 4'hD;
  // receive buffer
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_WIDTH = 12;
endpackage : uasfc_pkg

// ### logic/uasfc_fifo.sv
/*
  Receive word FIFO with valid/ready on both sides and a flush.
  Assumes DEPTH is a power of two; one clock, async active-low reset.
*/
`timescale 1ns/1ns
module uasfc_fifo #(
  parameter int WIDTH = uasfc_pkg::FIFO_WIDTH,
  parameter int DEPTH = uasfc_pkg::FIFO_DEPTH,
  localparam int AW = $clog2(DEPTH),
  localparam int CW = $clog2(DEPTH + 1)
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [CW-1:0] count
);
  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_chk
    $error("fifo depth must be a power of two of at least 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready = cnt_r != CW'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem[rp_r];
  assign count = cnt_r;

  always_comb
  begin
    push = in_valid && in_ready;
    pop = out_ready && out_valid;
    wp_nxt = push ? wp_r + AW'(1) : wp_r;
    rp_nxt = pop ? rp_r + AW'(1) : rp_r;
    cnt_nxt = cnt_r + CW'(push) - CW'(pop);
    if (flush)
    begin
      wp_nxt = '0;
      rp_nxt = '0;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage holds no reset so it maps onto plain RAM
  always_ff @(posedge mclk)
  begin
    if (push && !flush)
    begin
      mem[wp_r] <= in_data;
    end
  end
endmodule : uasfc_fifo

// ### logic/uasfc_top.sv
/*
  Serial port core: status and frame control registers, baud tick,
  receiver with majority vote, transmitter with parity, stop and break.
  Assumes the register port and serial pin input are synchronous to mclk.
*/
`timescale 1ns/1ns
module uasfc_top #(
  parameter int FIFO_DEPTH = uasfc_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // serial pins
  output logic tx_pin_o,
  output logic tx_pin_oe,
  input wire logic shared_pin_i,
  output logic shared_pin_o,
  output logic shared_pin_oe,
  // receive interrupt
  output logic rx_irq
);
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam int FW = uasfc_pkg::FIFO_WIDTH;
  if (FIFO_DEPTH < 2)
  begin : g_chk
    $error("receive buffer needs at least two words");
  end

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uasfc_rx_e;
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_BREAK} uasfc_tx_e;

  function automatic logic hit(input logic [2:0] idx, input logic strobe);
    return strobe && reg_addr == idx;
  endfunction : hit

  ////////////////////////////////////////////////////////////////////
  // registers and flags
  logic [7:0] c1_r, c1_nxt, c2_r, c2_nxt, c3_r, c3_nxt, baud_r, baud_nxt;
  logic [7:0] arm_r, arm_nxt, rdata_r, rdata_nxt, stat;
  logic perr_r, perr_nxt, noise_r, noise_nxt, ferr_r, ferr_nxt;
  logic ovr_r, ovr_nxt, ravail_r, ravail_nxt, tidle_r, tidle_nxt;
  logic tempty_r, tempty_nxt, tfull_r, tfull_nxt;
  logic [8:0] tbuf_r, tbuf_nxt;
  logic txo_r, txo_nxt, txoe_r, txoe_nxt, sho_r, sho_nxt, shoe_r, shoe_nxt;
  logic irq_r, irq_nxt;
  logic port_en, tx_on, rx_on, dlen, pen, ptype;
  logic rd_data, wr_data, clr_seq, tx_take, tx_line, brk_busy;
  logic push, fifo_rdy, fifo_vld;
  logic [FW-1:0] push_word, head;
  logic [CW-1:0] fifo_cnt;
  uasfc_rx_e rx_st_r, rx_st_nxt;
  uasfc_tx_e tx_st_r, tx_st_nxt;

  assign port_en = c1_r[uasfc_pkg::C1_EN];
  assign dlen = c1_r[uasfc_pkg::C1_DLEN];
  assign pen = c1_r[uasfc_pkg::C1_PEN];
  assign ptype = c1_r[uasfc_pkg::C1_PTYPE];
  assign tx_on = port_en && c2_r[uasfc_pkg::C2_TXEN];
  assign rx_on = port_en && c2_r[uasfc_pkg::C2_RXEN];
  // decoded in place: a continuous assign would miss address changes read inside hit
  assign rd_data = reg_rd && reg_addr == uasfc_pkg::IDX_DATA;
  assign wr_data = reg_wr && reg_addr == uasfc_pkg::IDX_DATA;
  assign clr_seq = rd_data || wr_data;

  always_comb
  begin
    stat = {perr_r, noise_r, ferr_r, ovr_r, rx_st_r == RX_IDLE,
            ravail_r, tidle_r, tempty_r};
    {c1_nxt, c2_nxt, c3_nxt, baud_nxt} = {c1_r, c2_r, c3_r, baud_r};
    tbuf_nxt = tbuf_r;
    rdata_nxt = rdata_r;
    if (hit(uasfc_pkg::IDX_CTRL1, reg_wr))
    begin
      c1_nxt = reg_wdata;
      c1_nxt[uasfc_pkg::C1_RX9] = 1'b0;
    end
    if (hit(uasfc_pkg::IDX_CTRL2, reg_wr))
      c2_nxt = reg_wdata;
    if (hit(uasfc_pkg::IDX_CTRL3, reg_wr))
      c3_nxt = {7'h00, reg_wdata[uasfc_pkg::C3_SWM]};
    if (hit(uasfc_pkg::IDX_BAUD, reg_wr))
      baud_nxt = reg_wdata;
    // shifter takes the old word first so a same-cycle write is kept
    tfull_nxt = tfull_r && !tx_take;
    if (wr_data)
    begin
      tbuf_nxt = {c1_r[uasfc_pkg::C1_TX9], reg_wdata};
      tfull_nxt = 1'b1;
    end
    // a status read only snapshots flags; the data access clears
    arm_nxt = hit(uasfc_pkg::IDX_STATUS, reg_rd) ? stat :
              (clr_seq ? 8'h00 : arm_r);
    // hardware set wins over the software clear sequence, except for tidle_r, whose set needs no data write
    ravail_nxt = (push && fifo_rdy) || (ravail_r && !(rd_data
                 && arm_r[uasfc_pkg::ST_RAVAIL] && fifo_cnt <= CW'(1)));
    perr_nxt = (push && fifo_rdy && push_word[11]) ||
               (perr_r && !(clr_seq && arm_r[uasfc_pkg::ST_PERR]));
    ferr_nxt = (push && fifo_rdy && push_word[10]) ||
               (ferr_r && !(clr_seq && arm_r[uasfc_pkg::ST_FERR]));
    noise_nxt = (push && fifo_rdy && push_word[9]) ||
                (noise_r && !(clr_seq && arm_r[uasfc_pkg::ST_NOISE]));
    ovr_nxt = (push && !fifo_rdy) ||
              (ovr_r && !(clr_seq && arm_r[uasfc_pkg::ST_OVR]));
    tempty_nxt = tx_take ||
                 (hit(uasfc_pkg::IDX_CTRL2, reg_wr) && reg_wdata[uasfc_pkg::C2_TXEN] &&
                  !c2_r[uasfc_pkg::C2_TXEN]) ||
                 (tempty_r && !(wr_data && arm_r[uasfc_pkg::ST_TEMPTY]));
    tidle_nxt = (tempty_r && !tfull_r && !wr_data && tx_st_r == TX_IDLE
                 && !c1_r[uasfc_pkg::C1_BRK]) ||
                (tidle_r && tx_st_r == TX_IDLE &&
                 !(wr_data && arm_r[uasfc_pkg::ST_TIDLE]));
    if (!port_en)
    begin
      c2_nxt[uasfc_pkg::C2_TXEN] = 1'b0;
      c2_nxt[uasfc_pkg::C2_RXEN] = 1'b0;
      c1_nxt[uasfc_pkg::C1_BRK] = 1'b0;
      {perr_nxt, noise_nxt, ferr_nxt, ovr_nxt, ravail_nxt} = 5'h00;
      {tidle_nxt, tempty_nxt} = 2'h3;
      tfull_nxt = 1'b0;
      arm_nxt = 8'h00;
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        uasfc_pkg::IDX_STATUS: rdata_nxt = stat;
        uasfc_pkg::IDX_CTRL1: rdata_nxt = {c1_r[7:2], head[8], 1'b0};
        uasfc_pkg::IDX_CTRL2: rdata_nxt = c2_r;
        uasfc_pkg::IDX_CTRL3: rdata_nxt = c3_r;
        uasfc_pkg::IDX_DATA: rdata_nxt = head[7:0];
        uasfc_pkg::IDX_BAUD: rdata_nxt = baud_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
    txo_nxt = tidle_nxt ? 1'b1 : tx_line;
    sho_nxt = txo_nxt;
    txoe_nxt = tx_on;
    shoe_nxt = tx_on && c3_r[uasfc_pkg::C3_SWM] && !c2_r[uasfc_pkg::C2_RXEN];
    irq_nxt = ravail_nxt && c2_r[uasfc_pkg::C2_RIE];
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {c1_r, c2_r, c3_r} <= {3{uasfc_pkg::CTRL_RST}};
      baud_r <= uasfc_pkg::BAUD_RST;
      {arm_r, rdata_r} <= 16'h0000;
      {perr_r, noise_r, ferr_r, ovr_r, ravail_r} <= 5'h00;
      {tidle_r, tempty_r, tfull_r} <= 3'h6;
      tbuf_r <= 9'h000;
      {txo_r, txoe_r, sho_r, shoe_r, irq_r} <= 5'h14;
    end
    else
    begin
      {c1_r, c2_r, c3_r, baud_r} <= {c1_nxt, c2_nxt, c3_nxt, baud_nxt};
      {arm_r, rdata_r} <= {arm_nxt, rdata_nxt};
      {perr_r, noise_r, ferr_r, ovr_r, ravail_r} <=
        {perr_nxt, noise_nxt, ferr_nxt, ovr_nxt, ravail_nxt};
      {tidle_r, tempty_r, tfull_r} <= {tidle_nxt, tempty_nxt, tfull_nxt};
      tbuf_r <= tbuf_nxt;
      {txo_r, txoe_r, sho_r, shoe_r, irq_r} <=
        {txo_nxt, txoe_nxt, sho_nxt, shoe_nxt, irq_nxt};
    end
  end

  assign reg_rdata = rdata_r;
  assign tx_pin_o = txo_r;
  assign tx_pin_oe = txoe_r;
  assign shared_pin_o = sho_r;
  assign shared_pin_oe = shoe_r;
  assign rx_irq = irq_r;

  ////////////////////////////////////////////////////////////////////
  // baud tick: sixteen ticks per bit, rate mclk / (divisor + 1) / 16
  logic [7:0] bcnt_r, bcnt_nxt;
  logic tick;

  always_comb
  begin
    tick = port_en && bcnt_r == baud_r;
    bcnt_nxt = (!port_en || tick) ? 8'h00 : bcnt_r + 8'h01;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      bcnt_r <= 8'h00;
    else
      bcnt_r <= bcnt_nxt;
  end

  ////////////////////////////////////////////////////////////////////
  // receiver: three-sample vote mid bit, mixed votes flag noise
  logic [3:0] rx_os_r, rx_os_nxt, rx_idx_r, rx_idx_nxt;
  logic [8:0] rx_sh_r, rx_sh_nxt, rx_word;
  logic [1:0] ones_r, ones_nxt;
  logic rx_nz_r, rx_nz_nxt, rx_par_r, rx_par_nxt, rx_bit, vote_nz;

  always_comb
  begin
    rx_st_nxt = rx_st_r;
    {rx_os_nxt, rx_idx_nxt} = {rx_os_r, rx_idx_r};
    {rx_sh_nxt, ones_nxt, rx_nz_nxt, rx_par_nxt} = {rx_sh_r, ones_r, rx_nz_r, rx_par_r};
    rx_bit = ones_r[1];
    vote_nz = ones_r[1] ^ ones_r[0];
    push = 1'b0;
    rx_word = rx_sh_r;
    if (pen)
    begin
      if (dlen)
        rx_word[8] = 1'b0;
      else
        rx_word[7] = 1'b0;
    end
    push_word = {pen && (rx_par_r != ptype), !rx_bit, rx_nz_r || vote_nz,
                 rx_word};
    if (!rx_on)
      rx_st_nxt = RX_IDLE;
    else if (tick)
    begin
      if (rx_st_r == RX_IDLE)
      begin
        if (!shared_pin_i)
        begin
          rx_st_nxt = RX_START;
          {rx_os_nxt, rx_idx_nxt, rx_sh_nxt} = 17'h00000;
          {ones_nxt, rx_nz_nxt, rx_par_nxt} = 4'h0;
        end
      end
      else
      begin
        rx_os_nxt = rx_os_r + 4'h1;
        if (rx_os_r >= uasfc_pkg::OS_VOTE_LO && rx_os_r <= uasfc_pkg::OS_VOTE_HI &&
            shared_pin_i)
          ones_nxt = ones_r + 2'h1;
        if (rx_os_r == uasfc_pkg::OS_LAST)
        begin
          ones_nxt = 2'h0;
          rx_nz_nxt = rx_nz_r || vote_nz;
          unique case (rx_st_r)
            RX_IDLE: rx_st_nxt = RX_IDLE;
            RX_START: rx_st_nxt = rx_bit ? RX_IDLE : RX_DATA;
            RX_DATA:
            begin
              rx_sh_nxt[rx_idx_r] = rx_bit;
              rx_par_nxt = rx_par_r ^ rx_bit;
              rx_idx_nxt = rx_idx_r + 4'h1;
              if (rx_idx_r == (dlen ? 4'h8 : 4'h7))
                rx_st_nxt = RX_STOP;
            end
            RX_STOP:
            begin
              push = 1'b1;
              rx_st_nxt = RX_IDLE;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_st_r <= RX_IDLE;
      {rx_os_r, rx_idx_r, rx_sh_r} <= 17'h00000;
      {ones_r, rx_nz_r, rx_par_r} <= 4'h0;
    end
    else
    begin
      rx_st_r <= rx_st_nxt;
      {rx_os_r, rx_idx_r, rx_sh_r} <= {rx_os_nxt, rx_idx_nxt, rx_sh_nxt};
      {ones_r, rx_nz_r, rx_par_r} <= {ones_nxt, rx_nz_nxt, rx_par_nxt};
    end
  end

  // a full buffer refuses the word, which raises overrun
  uasfc_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .flush(!port_en),
    .in_valid(push),
    .in_ready(fifo_rdy),
    .in_data(push_word),
    .out_valid(fifo_vld),
    .out_ready(rd_data),
    .out_data(head),
    .count(fifo_cnt)
  );

  ////////////////////////////////////////////////////////////////////
  // transmitter: frame is start, payload, stop bits, LSB first
  logic [12:0] fr_r, fr_nxt;
  logic [3:0] tx_os_r, tx_os_nxt, left_r, left_nxt;
  logic [8:0] pay;

  always_comb
  begin
    tx_st_nxt = tx_st_r;
    {fr_nxt, tx_os_nxt, left_nxt} = {fr_r, tx_os_r, left_r};
    tx_take = 1'b0;
    brk_busy = tx_st_r == TX_BREAK;
    tx_line = brk_busy ? 1'b0 : (tx_st_r == TX_SHIFT ? fr_r[0] : 1'b1);
    pay = tbuf_r;
    if (!dlen)
      pay[8] = 1'b1;
    if (pen)
    begin
      if (dlen)
        pay[8] = (^tbuf_r[7:0]) ^ ptype;
      else
        pay[7] = (^tbuf_r[6:0]) ^ ptype;
    end
    if (!tx_on)
      tx_st_nxt = TX_IDLE;
    else
    begin
      unique case (tx_st_r)
        TX_IDLE:
          if (tfull_r)
          begin
            tx_take = 1'b1;
            tx_st_nxt = TX_SHIFT;
            fr_nxt = {3'h7, pay, 1'b0};
            // count spans start, payload and every stop bit, less one
            left_nxt = (dlen ? 4'hA : 4'h9) + {3'h0, c1_r[uasfc_pkg::C1_STOP]};
            tx_os_nxt = 4'h0;
          end
          else if (c1_r[uasfc_pkg::C1_BRK])
          begin
            tx_st_nxt = TX_BREAK;
            {left_nxt, tx_os_nxt} = 8'h00;
          end
        TX_SHIFT:
          if (tick)
          begin
            tx_os_nxt = tx_os_r + 4'h1;
            if (tx_os_r == uasfc_pkg::OS_LAST)
            begin
              fr_nxt = {1'b1, fr_r[12:1]};
              left_nxt = left_r - 4'h1;
              if (left_r == 4'h0)
                tx_st_nxt = TX_IDLE;
            end
          end
        TX_BREAK:
        begin
          if (tick)
          begin
            tx_os_nxt = tx_os_r + 4'h1;
            if (tx_os_r == uasfc_pkg::OS_LAST && left_r != uasfc_pkg::BREAK_BITS)
              left_nxt = left_r + 4'h1;
          end
          if (left_r == uasfc_pkg::BREAK_BITS && !c1_r[uasfc_pkg::C1_BRK])
            tx_st_nxt = TX_IDLE;
        end
        default: tx_st_nxt = TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_st_r <= TX_IDLE;
      fr_r <= 13'h1FFF;
      {tx_os_r, left_r} <= 8'h00;
    end
    else
    begin
      tx_st_r <= tx_st_nxt;
      fr_r <= fr_nxt;
      {tx_os_r, left_r} <= {tx_os_nxt, left_nxt};
    end
  end
endmodule : uasfc_top

// ### tb/uasfc_top_chk.sv
/*
  Port checker for the serial core.
  Assumes it is bound to uasfc_top and that mclk is the only clock.
*/
`timescale 1ns/1ns
module uasfc_top_chk #(
  parameter int FIFO_DEPTH = 32
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // pins and interrupt
  input wire logic tx_pin_o,
  input wire logic tx_pin_oe,
  input wire logic shared_pin_i,
  input wire logic shared_pin_o,
  input wire logic shared_pin_oe,
  input wire logic rx_irq
);
  logic [2:0] acc_r;
  logic [2:0] acc_nxt;
  logic off_w;
  logic st_rd;
  assign off_w = reg_wr && reg_addr == uasfc_pkg::IDX_CTRL1 && !reg_wdata[uasfc_pkg::C1_EN];
  assign st_rd = reg_rd && !reg_wr && reg_addr == uasfc_pkg::IDX_STATUS;
  // writes and data reads of the last three edges: the only legal causes of a drive change or an irq fall
  always_comb
  begin
    acc_nxt = {acc_r[1:0], reg_wr || (reg_rd && reg_addr == uasfc_pkg::IDX_DATA)};
  end
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      acc_r <= 3'h0;
    else
      acc_r <= acc_nxt;
  end
  ////////////////////////////////////////
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  a_oe_pair:
    assert property (shared_pin_oe |-> tx_pin_oe) else $error("shared pin driven alone");
  a_pins_same:
    assert property (shared_pin_o == tx_pin_o) else $error("pin levels differ");
  a_float_off:
    assert property (off_w |-> ##3 (!tx_pin_oe && !shared_pin_oe) [*2])
      else $error("pins driven after disable");
  a_irq_off:
    assert property (off_w |-> ##3 !rx_irq) else $error("irq after disable");
  a_status_off:
    assert property (off_w ##2 st_rd |=> reg_rdata == 8'h0B) else $error("status after disable");
  a_avail_held:
    assert property (st_rd ##1 (reg_rdata[uasfc_pkg::ST_RAVAIL] && !reg_rd && !reg_wr) ##1 st_rd
      |=> reg_rdata[uasfc_pkg::ST_RAVAIL]) else $error("status read cleared flag");
  a_irq_cause:
    assert property ($fell(rx_irq) |-> acc_r != 3'h0) else $error("irq fell without access");
  a_drive_cause:
    assert property ($rose(tx_pin_oe) |-> acc_r != 3'h0) else $error("drive rose without write");
  cover property (off_w ##2 st_rd);
  cover property ($fell(rx_irq));
  cover property (tx_pin_oe && !tx_pin_o);
  cover property (shared_pin_oe);
endmodule : uasfc_top_chk
bind uasfc_top uasfc_top_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tx_pin_o(tx_pin_o), .tx_pin_oe(tx_pin_oe),
  .shared_pin_i(shared_pin_i), .shared_pin_o(shared_pin_o), .shared_pin_oe(shared_pin_oe),
  .rx_irq(rx_irq)
);

// ### tb/uasfc_serial_model.sv
/*
  Far-side serial device: sends frames and decodes the transmit line.
  Assumes 16 mclk per bit and a line that idles high.
*/
`timescale 1ns/1ns
module uasfc_serial_model (
  // clock
  input wire logic mclk,
  // lines
  input wire logic line_i,
  output logic line_o
);
  initial line_o = 1'b1;
  task automatic send(input logic [8:0] d, input int n, input logic stp, input int gap);
    repeat (gap + 1) @(negedge mclk);
    line_o = 1'b0;
    repeat (16) @(negedge mclk);
    for (int i = 0; i < n; i++)
    begin
      line_o = d[i];
      repeat (16) @(negedge mclk);
    end
    // a low stop level lets a scenario force a framing fault
    line_o = stp;
    repeat (16) @(negedge mclk);
    line_o = 1'b1;
  endtask : send
  task automatic recv(input int n, output logic [8:0] d);
    d = 9'h000;
    @(negedge line_i);
    repeat (8) @(negedge mclk);
    for (int i = 0; i < n; i++)
    begin
      repeat (16) @(negedge mclk);
      d[i] = line_i;
    end
    repeat (16) @(negedge mclk);
  endtask : recv
endmodule : uasfc_serial_model

// ### tb/test_uart_status_and_frame_control.sv
/*
  Bench for the serial core: register tasks, one task per scenario.
  Assumes the far-side model, the bound checker and baud divisor 0.
*/
`timescale 1ns/1ns
module test_uart_status_and_frame_control;
  localparam logic [2:0] ST = uasfc_pkg::IDX_STATUS;
  localparam logic [2:0] C1 = uasfc_pkg::IDX_CTRL1;
  localparam logic [2:0] C2 = uasfc_pkg::IDX_CTRL2;
  localparam logic [2:0] DT = uasfc_pkg::IDX_DATA;
  logic mclk;
  logic rst_n;
  logic [2:0] reg_addr;
  logic reg_rd;
  logic reg_wr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic tx_pin_o;
  logic tx_pin_oe;
  logic shared_pin_i;
  logic shared_pin_o;
  logic shared_pin_oe;
  logic rx_irq;
  logic ext_o;
  logic ext_i;
  int n_fail = 0;
  int comparisons = 0;
  // undriven pins rest high on their pull-ups
  assign shared_pin_i = shared_pin_oe ? shared_pin_o : ext_o;
  assign ext_i = tx_pin_oe ? tx_pin_o : 1'b1;
  uasfc_top #(.FIFO_DEPTH(32)) uut (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tx_pin_o(tx_pin_o), .tx_pin_oe(tx_pin_oe),
    .shared_pin_i(shared_pin_i), .shared_pin_o(shared_pin_o), .shared_pin_oe(shared_pin_oe),
    .rx_irq(rx_irq)
  );
  uasfc_serial_model m (.mclk(mclk), .line_i(ext_i), .line_o(ext_o));
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  ////////////////////////////////////////
  task automatic ck(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : ck
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd
  task automatic rk(input logic [2:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    rd(a, d);
    ck(d, exp, what);
  endtask : rk
  ////////////////////////////////////////
  task automatic t_tx;
    logic [8:0] w;
    rk(ST, 8'h0B, "reset status");
    rk(3'h6, 8'h00, "unmapped");
    wr(C1, 8'h80);
    wr(C2, 8'hC4);
    rk(ST, 8'h0B, "tx enabled");
    ck({6'h00, tx_pin_oe, shared_pin_oe}, 8'h02, "drive");
    fork
      m.recv(8, w);
      begin
        wr(DT, 8'hA5);
        repeat (4) @(negedge mclk);
        rk(ST, 8'h09, "sending");
      end
    join
    ck(w[7:0], 8'hA5, "tx word");
    repeat (24) @(negedge mclk);
    rk(ST, 8'h0B, "tx idle");
    ck({7'h00, tx_pin_o}, 8'h01, "idle high");
    for (int p = 0; p < 2; p++)
    begin
      wr(C1, 8'hA0 | {3'h0, p[0], p[0], 3'h0});
      fork
        m.recv(8, w);
        wr(DT, 8'h03);
      join
      ck(w[7:0], {p[0], 7'h03}, "parity bit");
      // one stop bit is done by now; with p = 1 a second stop bit keeps the shifter busy
      repeat (12) @(negedge mclk);
      rk(ST, p[0] ? 8'h09 : 8'h0B, "stop bits");
      repeat (24) @(negedge mclk);
    end
    $display("test transmit done");
  endtask : t_tx
  task automatic t_rx;
    wr(C1, 8'h80);
    fork
      m.send(9'h05A, 8, 1'b1, 2);
      begin
        repeat (60) @(negedge mclk);
        rk(ST, 8'h03, "receiving");
      end
    join
    repeat (16) @(negedge mclk);
    rk(ST, 8'h0F, "arrived");
    ck({7'h00, rx_irq}, 8'h01, "irq");
    rk(ST, 8'h0F, "status kept");
    rk(DT, 8'h5A, "rx word");
    rk(ST, 8'h0B, "flag cleared");
    ck({7'h00, rx_irq}, 8'h00, "irq cleared");
    m.send(9'h0C3, 8, 1'b0, 0);
    repeat (16) @(negedge mclk);
    rk(ST, 8'h2F, "framing");
    rk(DT, 8'hC3, "bad stop word");
    rk(ST, 8'h0B, "errors cleared");
    wr(C1, 8'hE0);
    m.send(9'h101, 9, 1'b1, 1);
    repeat (16) @(negedge mclk);
    rk(ST, 8'h0F, "parity good");
    rk(C1, 8'hE0, "parity unstored");
    rk(DT, 8'h01, "nine bit");
    m.send(9'h001, 9, 1'b1, 1);
    repeat (16) @(negedge mclk);
    rk(ST, 8'h8F, "parity error");
    rk(DT, 8'h01, "nine bit");
    wr(C1, 8'hC0);
    m.send(9'h122, 9, 1'b1, 1);
    repeat (16) @(negedge mclk);
    rk(C1, 8'hC2, "ninth stored");
    rk(DT, 8'h22, "nine bit");
    $display("test receive done");
  endtask : t_rx
  task automatic t_fifo;
    logic [7:0] s;
    wr(C1, 8'h80);
    for (int i = 0; i < 33; i++)
      m.send({1'b0, i[7:0]}, 8, 1'b1, 0);
    repeat (16) @(negedge mclk);
    rk(ST, 8'h1F, "overrun");
    for (int i = 0; i < 32; i++)
    begin
      rd(ST, s);
      rk(DT, i[7:0], "drain");
    end
    rk(ST, 8'h0B, "drained");
    $display("test buffer done");
  endtask : t_fifo
  task automatic t_break;
    int n;
    n = 0;
    wr(C1, 8'h84);
    repeat (250)
    begin
      @(negedge mclk);
      n += int'(tx_pin_o === 1'b0);
    end
    ck({7'h00, n > 220}, 8'h01, "break low");
    rk(ST, 8'h09, "break busy");
    wr(C1, 8'h80);
    repeat (80) @(negedge mclk);
    ck({7'h00, tx_pin_o}, 8'h01, "break end");
    $display("test break done");
  endtask : t_break
  task automatic t_off;
    wr(C1, 8'hB0);
    m.send(9'h091, 8, 1'b1, 0);
    wr(DT, 8'h55);
    repeat (40) @(negedge mclk);
    wr(C1, 8'h30);
    rk(ST, 8'h0B, "disabled");
    rk(C2, 8'h04, "enables off");
    ck({6'h00, tx_pin_oe, shared_pin_oe}, 8'h00, "float");
    wr(C1, 8'hB0);
    rk(C1, 8'hB0, "config kept");
    rk(ST, 8'h0B, "flushed");
    wr(C2, 8'h84);
    wr(uasfc_pkg::IDX_CTRL3, 8'h01);
    @(negedge mclk);
    ck({6'h00, tx_pin_oe, shared_pin_oe}, 8'h03, "single wire drive");
    wr(uasfc_pkg::IDX_CTRL3, 8'h00);
    $display("test disable done");
  endtask : t_off
  ////////////////////////////////////////
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  initial
  begin
    rst_n = 1'b0;
    reg_addr = 3'h0;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    t_tx;
    t_rx;
    t_fifo;
    t_break;
    t_off;
    results;
  end
  // whole run needs about 7600 cycles
  initial
  begin
    repeat (30000) @(posedge mclk);
    n_fail++;
    $display("BAD %0t watchdog", $time);
    results;
  end
endmodule : test_uart_status_and_frame_control
